// ==== src/bis_defs.vh ====
// Purpose: constants for the battery impedance sequencer
// Assumes: 50 MHz clock, 8-bit register port
// Notes:   offsets are register addresses on the internal register port
`ifndef BIS_DEFS_VH
`define BIS_DEFS_VH

// ********************************************************************
// register offsets
// ********************************************************************
`define BIS_ADDR_STEP_TIMING    8'h0D
`define BIS_ADDR_MEASURE_CONFIG 8'h0E
`define BIS_ADDR_BATTERY_RESULT 8'h0F
`define BIS_ADDR_OPEN_RESULT    8'h10
`define BIS_ADDR_LOADED_RESULT  8'h11

// ********************************************************************
// field positions
// ********************************************************************
`define BIS_BATTERY_TIMING_HI   5
`define BIS_BATTERY_TIMING_LO   4
`define BIS_OPEN_TIMING_HI      3
`define BIS_OPEN_TIMING_LO      2
`define BIS_LOADED_TIMING_HI    1
`define BIS_LOADED_TIMING_LO    0
`define BIS_START_BIT           7
`define BIS_ABORT_BIT           6
`define BIS_EXTRA_SKIP_BIT      3
`define BIS_CURRENT_HI          2
`define BIS_CURRENT_LO          0

// ********************************************************************
// timing codes and reset values
// ********************************************************************
`define BIS_TM_SKIP             2'h0
`define BIS_TM_NOW              2'h1
`define BIS_TM_SHORT            2'h2
`define BIS_TM_LONG             2'h3
`define BIS_CURRENT_RESERVED    3'h7
`define BIS_TIMING_RESET        8'h00
`define BIS_CONFIG_RESET        4'h0
`define BIS_RESULT_RESET        8'h00

// ********************************************************************
// settle times
// ********************************************************************
`define BIS_CLOCK_HZ            50000000
`define BIS_SHORT_SETTLE_MS     10
`define BIS_LONG_SETTLE_MS      100

`endif

// ==== src/bis_sequencer.v ====
// Purpose: battery impedance measurement sequencer with its register file
// Assumes: registers reached over the device's internal register port
//          (serial controller already decoded); converter on same clock
// Notes:   steps run battery, open cell, loaded cell; each may be skipped
//
// Overview of operation
// - battery timing code picks skip, read now, or read after settle delay.
// - open-cell timing code picks skip, now, 10 ms or 100 ms settle.
// - loaded-cell timing code picks skip, now, 10 ms or longer settle.
// - open-cell step skipped means loaded reading taken with switch closed.
// - current code selects zero to 8 mA load; code 111 is never driven.
`timescale 1ns/1ns
`include "bis_defs.vh"

module bis_sequencer #(
  parameter integer SHORT_CYCLES = (`BIS_CLOCK_HZ / 1000) * `BIS_SHORT_SETTLE_MS,
  parameter integer LONG_CYCLES  = (`BIS_CLOCK_HZ / 1000) * `BIS_LONG_SETTLE_MS
) (
  input  wire       clock,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire       reg_write,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        convert_start,
  output reg  [1:0] convert_step,
  input  wire       convert_done,
  input  wire [7:0] convert_data,
  output reg        switch_closed,
  output reg        load_enable,
  output reg  [2:0] test_current_select,
  output wire       measure_start_active
);

  // ********************************************************************
  // local definitions
  // ********************************************************************
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_CONV   = 2'h2;
  localparam [1:0] STEP_BAT  = 2'h0;
  localparam [1:0] STEP_OPEN = 2'h1;
  localparam [1:0] STEP_LOAD = 2'h2;
  localparam [1:0] STEP_DONE = 2'h3;

  reg [7:0]  step_timing_reg;
  reg [3:0]  config_reg;          // extra skip bit and current code
  reg        active_reg;
  reg [1:0]  state_reg;
  reg [1:0]  step_reg;
  reg [22:0] wait_reg;
  reg [7:0]  battery_result_reg;
  reg [7:0]  open_result_reg;
  reg [7:0]  loaded_result_reg;

  wire       cfg_write   = reg_write && (reg_addr == `BIS_ADDR_MEASURE_CONFIG);
  wire       abort_write = cfg_write && reg_wdata[`BIS_ABORT_BIT];
  wire       start_write = cfg_write && reg_wdata[`BIS_START_BIT] && !active_reg;
  wire [1:0] bat_tm  = step_timing_reg[`BIS_BATTERY_TIMING_HI:`BIS_BATTERY_TIMING_LO];
  wire [1:0] open_tm = step_timing_reg[`BIS_OPEN_TIMING_HI:`BIS_OPEN_TIMING_LO];
  wire [1:0] load_tm = step_timing_reg[`BIS_LOADED_TIMING_HI:`BIS_LOADED_TIMING_LO];

  assign measure_start_active = active_reg;

  // ********************************************************************
  // helpers
  // ********************************************************************
  // timing code of a step; the done slot reads as skip
  function [1:0] step_code;
    input [1:0] step;
    input [1:0] b;
    input [1:0] o;
    input [1:0] l;
    begin
      case (step)
        STEP_BAT:  step_code = b;
        STEP_OPEN: step_code = o;
        STEP_LOAD: step_code = l;
        default:   step_code = `BIS_TM_SKIP;
      endcase
    end
  endfunction

  // settle count for a timing code, zero meaning convert at once
  function [22:0] settle_cycles;
    input [1:0] code;
    begin
      case (code)
        `BIS_TM_SHORT: settle_cycles = SHORT_CYCLES[22:0];
        `BIS_TM_LONG:  settle_cycles = LONG_CYCLES[22:0];
        default:       settle_cycles = 23'h000000;
      endcase
    end
  endfunction

  // first step at or after 'from' that is not skipped, else done
  function [1:0] next_step;
    input [1:0] from;
    input [1:0] b;
    input [1:0] o;
    input [1:0] l;
    begin
      if (from <= STEP_BAT && b != `BIS_TM_SKIP) begin
        next_step = STEP_BAT;
      end else if (from <= STEP_OPEN && o != `BIS_TM_SKIP) begin
        next_step = STEP_OPEN;
      end else if (from <= STEP_LOAD && l != `BIS_TM_SKIP) begin
        next_step = STEP_LOAD;
      end else begin
        next_step = STEP_DONE;
      end
    end
  endfunction

  // ********************************************************************
  // register writes
  // ********************************************************************
  // timing and config hold their values; abort and start are actions only
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step_timing_reg <= `BIS_TIMING_RESET;
      config_reg      <= `BIS_CONFIG_RESET;
    end else if (reg_write && reg_addr == `BIS_ADDR_STEP_TIMING) begin
      step_timing_reg <= {2'h0, reg_wdata[5:0]};
    end else if (cfg_write) begin
      config_reg <= reg_wdata[3:0];
    end
  end

  // ********************************************************************
  // sequence engine
  // ********************************************************************
  // abort is checked first so it beats any step change in the same cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      active_reg         <= 1'b0;
      state_reg          <= ST_IDLE;
      step_reg           <= STEP_BAT;
      wait_reg           <= 23'h000000;
      convert_start      <= 1'b0;
      battery_result_reg <= `BIS_RESULT_RESET;
      open_result_reg    <= `BIS_RESULT_RESET;
      loaded_result_reg  <= `BIS_RESULT_RESET;
    end else begin
      convert_start <= 1'b0;
      if (abort_write) begin
        active_reg <= 1'b0;
        state_reg  <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (start_write) begin
              active_reg <= 1'b1;
              step_reg   <= next_step(STEP_BAT, bat_tm, open_tm, load_tm);
              wait_reg   <= settle_cycles(step_code(next_step(STEP_BAT, bat_tm, open_tm, load_tm),
                                                    bat_tm, open_tm, load_tm));
              state_reg  <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            if (step_reg == STEP_DONE) begin
              active_reg <= 1'b0;
              state_reg  <= ST_IDLE;
            end else if (wait_reg != 23'h000000) begin
              wait_reg <= wait_reg - 23'h000001;
            end else begin
              convert_start <= 1'b1;
              state_reg     <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (convert_done) begin
              case (step_reg)
                STEP_BAT:  battery_result_reg <= convert_data;
                STEP_OPEN: open_result_reg    <= convert_data;
                default:   loaded_result_reg  <= convert_data;
              endcase
              step_reg  <= next_step(step_reg + 2'h1, bat_tm, open_tm, load_tm);
              wait_reg  <= settle_cycles(step_code(next_step(step_reg + 2'h1, bat_tm, open_tm, load_tm),
                                                   bat_tm, open_tm, load_tm));
              state_reg <= ST_SETTLE;
            end
          end
          default: begin
            active_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ********************************************************************
  // power path control
  // ********************************************************************
  // switch opens for the open and loaded steps so the cell is isolated;
  // with the open step skipped the loaded step keeps it closed instead
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      switch_closed       <= 1'b1;
      load_enable         <= 1'b0;
      test_current_select <= 3'h0;
      convert_step        <= STEP_BAT;
    end else begin
      convert_step  <= step_reg;
      switch_closed <= !(active_reg && (step_reg == STEP_OPEN ||
                         (step_reg == STEP_LOAD && open_tm != `BIS_TM_SKIP)));
      load_enable   <= active_reg && step_reg == STEP_LOAD && !abort_write;
      // reserved code never reaches the sink; it is driven as zero
      if (config_reg[2:0] == `BIS_CURRENT_RESERVED) begin
        test_current_select <= 3'h0;
      end else begin
        test_current_select <= config_reg[2:0];
      end
    end
  end

  // ********************************************************************
  // read data
  // ********************************************************************
  // abort reads as zero since it acts only at the write
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `BIS_ADDR_STEP_TIMING:    reg_rdata <= step_timing_reg;
        `BIS_ADDR_MEASURE_CONFIG: reg_rdata <= {active_reg, 3'h0, config_reg};
        `BIS_ADDR_BATTERY_RESULT: reg_rdata <= battery_result_reg;
        `BIS_ADDR_OPEN_RESULT:    reg_rdata <= open_result_reg;
        `BIS_ADDR_LOADED_RESULT:  reg_rdata <= loaded_result_reg;
        default:                  reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // bis_sequencer

// ==== dv/bis_sequencer_assertions.sv ====
// Purpose: port-level checker for the impedance sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   keeps its own copy of the step timing register
`timescale 1ns/1ns
module bis_sequencer_chk (
  input wire       clock,
  input wire       rstn,
  input wire [7:0] reg_addr,
  input wire       reg_write,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       convert_start,
  input wire [1:0] convert_step,
  input wire       convert_done,
  input wire [7:0] convert_data,
  input wire       switch_closed,
  input wire       load_enable,
  input wire [2:0] test_current_select,
  input wire       measure_start_active
);
  // ****
  // timing copy, so step rules can be judged from the ports
  // ****
  reg [7:0] tm_reg;
  wire      cfg_wr = reg_write && reg_addr == 8'h0E;
  wire      go_wr  = cfg_wr && reg_wdata[7:6] == 2'h2;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) tm_reg <= 8'h00;
    else if (reg_write && reg_addr == 8'h0D) tm_reg <= reg_wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_START_PULSE: assert property (convert_start |=> !convert_start)
    else $error("conversion request wider than one cycle");
  AST_NO_RESERVED: assert property (test_current_select != 3'h7)
    else $error("reserved current code driven");
  AST_START_TAKEN: assert property (go_wr && !measure_start_active |=> measure_start_active)
    else $error("start write not taken");
  AST_ABORT: assert property (cfg_wr && reg_wdata[6] |=> !measure_start_active[*2])
    else $error("abort did not stop sequence");
  AST_ONLY_ACTIVE: assert property (convert_start |-> measure_start_active)
    else $error("conversion while idle");
  AST_BAT_NOW: assert property (convert_start && convert_step == 2'h0 && tm_reg[5:4] == 2'h1
    |-> $past(go_wr, 2) || $past(go_wr, 3)) else $error("battery immediate read late");
  AST_OPEN_NOW: assert property (convert_start && convert_step == 2'h1 && tm_reg[3:2] == 2'h1
    |-> $past(convert_done, 2) || $past(convert_done, 3) || $past(go_wr, 2))
    else $error("open-cell immediate read late");
  AST_OPEN_SW: assert property (convert_done && convert_step == 2'h1 |-> !switch_closed)
    else $error("switch closed during open-cell read");
  AST_LOADED_SW: assert property (convert_done && convert_step == 2'h2
    |-> load_enable && switch_closed == (tm_reg[3:2] == 2'h0)) else $error("loaded step switch wrong");
  AST_FALL: assert property ($fell(measure_start_active) |-> $past(cfg_wr && reg_wdata[6])
    || $past(convert_done, 2) || $past(convert_done, 3) || $past(go_wr, 2)) else $error("active cleared early");
  cover property (convert_start && convert_step == 2'h2);
  cover property (cfg_wr && reg_wdata[6] && measure_start_active);
  cover property ($fell(measure_start_active));
endmodule // bis_sequencer_chk
bind bis_sequencer bis_sequencer_chk u_chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .convert_start(convert_start),
  .convert_step(convert_step), .convert_done(convert_done), .convert_data(convert_data),
  .switch_closed(switch_closed), .load_enable(load_enable), .test_current_select(test_current_select),
  .measure_start_active(measure_start_active));

// ==== dv/bis_cell_model.sv ====
// Purpose: battery path and converter seen from the sequencer
// Assumes: lat sets extra reply cycles, so replies can be prompt or slow
// Notes:   result encodes step, switch, load and current for the bench
`timescale 1ns/1ns
module bis_cell_model (
  input wire       clock, rstn, convert_start, switch_closed, load_enable,
  input wire [1:0] convert_step,
  input wire [2:0] test_current_select,
  input wire [3:0] lat,
  output reg       convert_done,
  output reg [7:0] convert_data
);
  integer wait_cnt;
  // ****
  // reply lat+1 cycles after the request is sampled; data toggles when not valid
  // ****
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= -1;
      convert_done <= 1'b0;
      convert_data <= 8'h55;
    end else begin
      convert_done <= 1'b0;
      convert_data <= ~convert_data; // no stale value outside a reply
      if (convert_start) wait_cnt <= lat;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 0) begin
        wait_cnt <= -1;
        convert_done <= 1'b1;
        convert_data <= {1'b1, convert_step, switch_closed, load_enable, load_enable ? test_current_select : 3'h0};
      end
    end
  end
endmodule // bis_cell_model

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the impedance sequencer
// Assumes: settle counts shortened to 5 and 20 cycles
// Notes:   results predicted from timing codes and switch/load choices
`timescale 1ns/1ns
module tb;
  reg        clock, rstn, reg_write;
  reg  [7:0] reg_addr, reg_wdata, tm;
  reg  [3:0] lat;
  reg [31:0] seed;
  reg  [7:0] exp_res [0:2];
  wire [7:0] reg_rdata, convert_data;
  wire       convert_start, convert_done, switch_closed, load_enable, measure_start_active;
  wire [1:0] convert_step;
  wire [2:0] test_current_select;
  integer    bad_count, checked, k, i, n, s;
  localparam [39:0] TBL = 40'h14113F2A15;
  bis_sequencer #(.SHORT_CYCLES(5), .LONG_CYCLES(20)) dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .convert_start(convert_start),
    .convert_step(convert_step), .convert_done(convert_done), .convert_data(convert_data),
    .switch_closed(switch_closed), .load_enable(load_enable), .test_current_select(test_current_select),
    .measure_start_active(measure_start_active));
  bis_cell_model far (.clock(clock), .rstn(rstn), .convert_start(convert_start), .switch_closed(switch_closed),
    .load_enable(load_enable), .convert_step(convert_step), .test_current_select(test_current_select),
    .lat(lat), .convert_done(convert_done), .convert_data(convert_data));
  // ****
  // helpers
  // ****
  function [31:0] lfsr(input [31:0] v); lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]}; endfunction
  function integer st(input [1:0] c); st = c == 2'h3 ? 20 : c == 2'h2 ? 5 : 0; endfunction
  task chk(input [7:0] g, input [7:0] e); begin
    checked = checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end endtask
  task wr(input [7:0] a, input [7:0] d); begin
    @(posedge clock); #1 reg_addr = a; reg_wdata = d; reg_write = 1'b1;
    @(posedge clock); #1 reg_write = 1'b0;
  end endtask
  task rd(input [7:0] a, input [7:0] e); begin
    @(posedge clock); #1 reg_addr = a;
    @(posedge clock); @(posedge clock); #1 chk(reg_rdata, e);
  end endtask
  task close_out; begin
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  // one sequence; a second start while busy must change nothing
  task run(input [7:0] t, input [2:0] c); begin
    wr(8'h0D, t);
    wr(8'h0E, {5'h10, c});
    chk({7'h0, measure_start_active}, 8'h01);
    wr(8'h0E, {5'h10, c});
    n = 0;
    while (measure_start_active === 1'b1 && n < 400) begin @(posedge clock); #1 n = n + 1; end
    s = st(t[5:4]) + st(t[3:2]) + st(t[1:0]);
    chk((n + 4 >= s && n <= s + 40) ? 8'h01 : 8'h00, 8'h01);
    for (i = 0; i < 3; i = i + 1)
      if (t[5 - 2 * i -: 2] != 2'h0)
        exp_res[i] = {1'b1, i[1:0], i == 0 || (i == 2 && t[3:2] == 2'h0), i == 2, i == 2 && c != 3'h7 ? c : 3'h0};
    for (i = 0; i < 3; i = i + 1) rd(8'h0F + i, exp_res[i]);
  end endtask
  initial begin clock = 1'b0; forever #10 clock = ~clock; end
  initial begin #400000; bad_count = bad_count + 1; close_out; end
  // ****
  // main sequence
  // ****
  initial begin
    rstn = 1'b0; reg_write = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; lat = 4'h0;
    bad_count = 0; checked = 0; seed = 32'hED577DC9;
    for (i = 0; i < 3; i = i + 1) exp_res[i] = 8'h00;
    repeat (3) @(posedge clock); #1 rstn = 1'b1;
    rd(8'h0F, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      seed = lfsr(seed);
      lat = {1'b0, seed[2:0]};
      tm = k < 5 ? TBL[8 * k +: 8] : {2'h0, seed[13:8]} | 8'h01;
      run(tm, k[2:0]);
    end
    wr(8'h0D, 8'h3F);
    rd(8'h0D, 8'h3F);
    wr(8'h0E, 8'h80);
    repeat (3) @(posedge clock);
    wr(8'h0E, 8'h40);
    @(posedge clock); #1 chk({7'h0, measure_start_active}, 8'h00);
    for (i = 0; i < 3; i = i + 1) rd(8'h0F + i, exp_res[i]);
    wr(8'h0E, 8'hC0);
    @(posedge clock); #1 chk({7'h0, measure_start_active}, 8'h00);
    wr(8'h0E, 8'h0B);
    rd(8'h0E, 8'h0B);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, exp_res[0]);
    rd(8'h12, 8'h00);
    close_out;
  end
endmodule // tb
